/* File: core/mcast_class_consts.vh */
// constants for the ipv6 multicast class filter
`ifndef MCAST_CLASS_CONSTS_VH
`define MCAST_CLASS_CONSTS_VH
`define MAC_ALL_NODES 48'h333300000001
`define MAC_DHCP_RELAY 48'h333300010002
`define MAC_DHCP_SERVERS 48'h333300010003
`define ETYPE_IPV6 16'h86dd
`define NH_ICMPV6 8'h3a
`define NH_UDP 8'h11
`define ICMP_ROUTER_ADV 8'h86
`define UDP_PORT_SERVER 16'h0223
`define UDP_PORT_CLIENT 16'h0222
`define OFS_ETYPE_HI 11'h00c
`define OFS_ETYPE_LO 11'h00d
`define OFS_NEXT_HDR 11'h014
`define OFS_L4_B0 11'h036
`define OFS_L4_B2 11'h038
`define OFS_L4_B3 11'h039
`define OFS_LAST_MAC 11'h005
`define SET_BIT_RA 1
`define SET_BIT_RELAY 2
`define SET_BIT_CLIENT 3
`endif

/* File: core/frame_field_capture.v */
// captures header fields of a received frame byte by byte
`timescale 1ns/1ns
`include "mcast_class_consts.vh"
module frame_field_capture (
	input wire clk,
	input wire arst_n,
	input wire byte_valid,
	input wire [7:0] byte_data,
	input wire frame_start,
	output reg [47:0] dst_mac_q,
	output reg [15:0] etype_q,
	output reg [7:0] next_hdr_q,
	output reg [7:0] icmp_type_q,
	output reg [15:0] udp_dport_q,
	output reg [10:0] index_q
);
	always @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			dst_mac_q <= 48'h000000000000;
			etype_q <= 16'h0000;
			next_hdr_q <= 8'h00;
			icmp_type_q <= 8'h00;
			udp_dport_q <= 16'h0000;
			index_q <= 11'h000;
		end
		else if (byte_valid)
		begin
			// index restarts on the first byte so a frame start needs no idle gap
			if (frame_start)
				index_q <= 11'h001;
			else if (index_q != 11'h7ff)
				index_q <= index_q + 11'h001;
			if (frame_start)
				dst_mac_q <= {byte_data, 40'h0000000000};
			else if (index_q <= `OFS_LAST_MAC)
				dst_mac_q[47 - index_q * 8 -: 8] <= byte_data;
			if (!frame_start && index_q == `OFS_ETYPE_HI)
				etype_q[15:8] <= byte_data;
			if (!frame_start && index_q == `OFS_ETYPE_LO)
				etype_q[7:0] <= byte_data;
			if (!frame_start && index_q == `OFS_NEXT_HDR)
				next_hdr_q <= byte_data;
			if (!frame_start && index_q == `OFS_L4_B0)
				icmp_type_q <= byte_data;
			if (!frame_start && index_q == `OFS_L4_B2)
				udp_dport_q[15:8] <= byte_data;
			if (!frame_start && index_q == `OFS_L4_B3)
				udp_dport_q[7:0] <= byte_data;
		end
	end
endmodule // frame_field_capture

/* File: core/ipv6_multicast_class_filter.v */
// classifies received frames into optional ipv6 multicast classes
`timescale 1ns/1ns
`include "mcast_class_consts.vh"
module ipv6_multicast_class_filter #(
	parameter HAS_RA = 1'b1,
	parameter HAS_RELAY = 1'b1,
	parameter HAS_CLIENT = 1'b1
) (
	input wire CLK,
	input wire ARST_N,
	input wire RX_VALID,
	input wire [7:0] RX_DATA,
	input wire RX_SOF,
	input wire RX_EOF,
	input wire GLOBAL_FILTER_EN,
	input wire ADDR_MATCH,
	input wire [3:1] FILTER_SETTINGS,
	output reg VERDICT_VALID,
	output reg FORWARD,
	output reg [3:1] CLASS_HIT,
	output reg [3:1] SUPPORTED
);
	wire [47:0] mac;
	wire [15:0] etype;
	wire [7:0] nh;
	wire [7:0] icmp_type;
	wire [15:0] dport;
	wire [10:0] idx;
	reg [47:0] mac_n;
	reg [15:0] etype_n;
	reg [7:0] nh_n;
	reg [7:0] icmp_n;
	reg [15:0] dport_n;
	reg is_v6;
	reg is_icmp;
	reg is_udp;
	reg mac_ra;
	reg mac_relay;
	reg mac_client;
	reg hit_ra;
	reg hit_relay;
	reg hit_client;
	reg is_mcast;
	reg pass_plain;
	reg fwd_d;
	wire [3:1] impl;
	wire [3:1] raw_hit;
	wire [3:1] hit_d;
	wire [3:1] en_d;
	wire [3:1] gated;
	wire frame_end;

	assign impl = {HAS_CLIENT[0], HAS_RELAY[0], HAS_RA[0]};
	assign raw_hit = {hit_client, hit_relay, hit_ra};
	assign frame_end = RX_VALID && RX_EOF;

	frame_field_capture u_capture (
		.clk(CLK),
		.arst_n(ARST_N),
		.byte_valid(RX_VALID),
		.byte_data(RX_DATA),
		.frame_start(RX_SOF),
		.dst_mac_q(mac),
		.etype_q(etype),
		.next_hdr_q(nh),
		.icmp_type_q(icmp_type),
		.udp_dport_q(dport),
		.index_q(idx)
	);

	// fold in the byte arriving with the end flag so short frames still classify
	always @*
	begin
		mac_n = mac;
		etype_n = etype;
		nh_n = nh;
		icmp_n = icmp_type;
		dport_n = dport;
		if (RX_VALID && !RX_SOF)
		begin
			if (idx <= `OFS_LAST_MAC)
			begin
				mac_n[47 - idx * 8 -: 8] = RX_DATA;
			end
			if (idx == `OFS_ETYPE_LO)
			begin
				etype_n[7:0] = RX_DATA;
			end
			if (idx == `OFS_NEXT_HDR)
			begin
				nh_n = RX_DATA;
			end
			if (idx == `OFS_L4_B0)
			begin
				icmp_n = RX_DATA;
			end
			if (idx == `OFS_L4_B3)
			begin
				dport_n[7:0] = RX_DATA;
			end
		end
	end

	// shared header tests
	always @*
	begin
		is_v6 = (etype_n == `ETYPE_IPV6);
		is_icmp = (nh_n == `NH_ICMPV6);
		is_udp = (nh_n == `NH_UDP);
		is_mcast = mac_n[40];
	end

	// destination address tests per class
	always @*
	begin
		mac_ra = (mac_n == `MAC_ALL_NODES);
		mac_relay = (mac_n == `MAC_DHCP_RELAY) || (mac_n == `MAC_DHCP_SERVERS);
		mac_client = (mac_n == `MAC_DHCP_RELAY);
	end

	// all conditions anded per class
	always @*
	begin
		hit_ra = is_v6 && mac_ra && is_icmp && (icmp_n == `ICMP_ROUTER_ADV);
	end

	// port only counts once udp is confirmed
	always @*
	begin
		hit_relay = is_v6 && mac_relay && is_udp && (dport_n == `UDP_PORT_SERVER);
	end

	// shares MAC_DHCP_RELAY with the relay class, but the two need different ports, so they never both hit on one frame
	always @*
	begin
		hit_client = is_v6 && mac_client && is_udp && (dport_n == `UDP_PORT_CLIENT);
	end

	// one gate per class; an omitted class never hits, whatever its bit says
	genvar c;
	generate
		for (c = 1; c <= 3; c = c + 1)
		begin : g_class
			assign hit_d[c] = raw_hit[c] & impl[c];
			assign en_d[c] = FILTER_SETTINGS[c] & impl[c];
			assign gated[c] = hit_d[c] & en_d[c];
		end
	endgenerate

	// non-multicast traffic and unfiltered mode bypass the classes
	always @*
	begin
		pass_plain = !is_mcast || !GLOBAL_FILTER_EN || ADDR_MATCH;
		// one verdict per frame, or of enabled hits
		fwd_d = pass_plain
			|| gated[`SET_BIT_RA]
			|| gated[`SET_BIT_RELAY]
			|| gated[`SET_BIT_CLIENT];
	end

	// capability bits are constant but still leave through a flop
	always @(posedge CLK or negedge ARST_N)
	begin
		if (!ARST_N)
		begin
			SUPPORTED <= 3'h0;
		end
		else
		begin
			SUPPORTED <= impl;
		end
	end

	// one pulse per frame end
	always @(posedge CLK or negedge ARST_N)
	begin
		if (!ARST_N)
		begin
			VERDICT_VALID <= 1'b0;
		end
		else
		begin
			VERDICT_VALID <= frame_end;
		end
	end

	// verdict holds between frames so a slow reader sees the last one
	always @(posedge CLK or negedge ARST_N)
	begin
		if (!ARST_N)
		begin
			FORWARD <= 1'b0;
		end
		else if (frame_end)
		begin
			FORWARD <= fwd_d;
		end
	end

	always @(posedge CLK or negedge ARST_N)
	begin
		if (!ARST_N)
		begin
			CLASS_HIT <= 3'h0;
		end
		else if (frame_end)
		begin
			CLASS_HIT <= hit_d;
		end
	end
endmodule // ipv6_multicast_class_filter

/* File: tb/filter_props.sv */
// checker on the multicast class filter ports
`timescale 1ns/1ns
module filter_props (
	input wire CLK,
	input wire ARST_N,
	input wire RX_VALID,
	input wire RX_EOF,
	input wire ADDR_MATCH,
	input wire GLOBAL_FILTER_EN,
	input wire [3:1] FILTER_SETTINGS,
	input wire VERDICT_VALID,
	input wire FORWARD,
	input wire [3:1] CLASS_HIT,
	input wire [3:1] SUPPORTED
);
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!ARST_N);
	a_verdict_follows: assert property (RX_VALID && RX_EOF |=> VERDICT_VALID) else $error("late");
	a_verdict_cause: assert property (VERDICT_VALID |-> $past(RX_EOF)) else $error("cause");
	a_fwd_holds: assert property (!VERDICT_VALID |-> $stable(FORWARD)) else $error("fwd");
	a_hit_holds: assert property (!VERDICT_VALID |-> $stable(CLASS_HIT)) else $error("hit");
	a_ra_gate: assert property (VERDICT_VALID && CLASS_HIT[1] && $past(FILTER_SETTINGS[1]) |-> FORWARD)
		else $error("ra");
	a_relay_gate: assert property (VERDICT_VALID && CLASS_HIT[2] && $past(FILTER_SETTINGS[2]) |-> FORWARD)
		else $error("relay");
	a_client_gate: assert property (VERDICT_VALID && CLASS_HIT[3] && $past(FILTER_SETTINGS[3]) |-> FORWARD)
		else $error("client");
	a_addr_pass: assert property (VERDICT_VALID && $past(ADDR_MATCH) |-> FORWARD) else $error("addr");
	a_open_pass: assert property (VERDICT_VALID && !$past(GLOBAL_FILTER_EN) |-> FORWARD) else $error("open");
	a_support_kept: assert property ($past(VERDICT_VALID) |-> $stable(SUPPORTED)) else $error("support");
endmodule // filter_props
bind ipv6_multicast_class_filter filter_props filter_props_inst (.CLK, .ARST_N, .RX_VALID, .RX_EOF,
	.ADDR_MATCH, .GLOBAL_FILTER_EN, .FILTER_SETTINGS, .VERDICT_VALID, .FORWARD, .CLASS_HIT, .SUPPORTED);

/* File: tb/frame_source.sv */
// far-side frame source feeding receive bytes
`timescale 1ns/1ns
module frame_source (
	input wire clk,
	input wire go,
	input wire [95:0] f,
	output reg valid = 1'b0,
	output reg [7:0] data = 8'h00,
	output reg sof = 1'b0,
	output reg eof = 1'b0
);
	integer i;
	always @(posedge go)
	begin
		for (i = 0; i < 58; i = i + 1)
		begin
			@(negedge clk);
			valid = 1'b1;
			sof = (i == 0);
			eof = (i == 57);
			data = i < 6 ? f[95 - 8 * i -: 8] : i == 12 ? f[47:40] : i == 13 ? f[39:32] :
				i == 20 ? f[31:24] : i == 54 ? f[23:16] : i == 56 ? f[15:8] : i == 57 ? f[7:0] : i[7:0];
		end
		@(negedge clk);
		{valid, sof, eof} = 3'h0;
		// idle bytes must not look like the last one
		data = ~data;
	end
endmodule // frame_source

/* File: tb/ipv6_multicast_class_filter_bench.sv */
// testbench for the multicast class filter
`timescale 1ns/1ns
module ipv6_multicast_class_filter_bench;
	localparam [47:0] m1 = 48'h333300000001;
	localparam [47:0] m2 = 48'h333300010002;
	localparam [47:0] m3 = 48'h333300010003;
	reg clk = 1'b0, arst_n = 1'b0, go = 1'b0, gf = 1'b0, am = 1'b0;
	reg [3:1] set = 3'h0;
	reg [95:0] f = 96'h0;
	reg [15:0] et = 16'h86dd;
	wire rv, sof, eof, vv, fwd;
	wire [7:0] rd;
	wire [3:1] hit, sup;
	integer bad_count = 0, checks_done = 0, n;
	frame_source frame_source_inst (.clk(clk), .go(go), .f(f), .valid(rv), .data(rd), .sof(sof),
		.eof(eof));
	ipv6_multicast_class_filter ipv6_multicast_class_filter_inst (.CLK(clk), .ARST_N(arst_n),
		.RX_VALID(rv), .RX_DATA(rd), .RX_SOF(sof), .RX_EOF(eof), .GLOBAL_FILTER_EN(gf),
		.ADDR_MATCH(am), .FILTER_SETTINGS(set), .VERDICT_VALID(vv), .FORWARD(fwd),
		.CLASS_HIT(hit), .SUPPORTED(sup));
	initial forever #25 clk = ~clk;
	task end_of_test;
	begin
		$display("checks %0d bad %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	end
	endtask
	task chk(input [47:0] m, input [7:0] h, input [7:0] k, input [15:0] p, input [3:1] s,
		input [3:1] x);
	begin
		@(negedge clk);
		f = {m, et, h, k, p};
		set = s;
		go = 1'b1;
		@(negedge clk);
		go = 1'b0;
		for (n = 0; n < 99 && vv !== 1'b1; n = n + 1)
			@(negedge clk);
		checks_done = checks_done + 1;
		if (vv !== 1'b1 || hit !== x || fwd !== (am | !gf | (|(x & s))))
		begin
			bad_count = bad_count + 1;
			$display("BAD %0t hit %b fwd %b", $time, hit, fwd);
		end
	end
	endtask
	task t_ra;
	begin
		chk(m1, 8'h3a, 8'h86, 16'h0, 3'b000, 3'b001);
		chk(m1, 8'h3a, 8'h86, 16'h0, 3'b001, 3'b001);
		chk(m1, 8'h11, 8'h86, 16'h0, 3'b001, 3'b000);
		chk(m1, 8'h3a, 8'h88, 16'h0, 3'b001, 3'b000);
		chk(m2, 8'h3a, 8'h86, 16'h0, 3'b001, 3'b000);
		$display("ra end");
	end
	endtask
	task t_dhcp;
	begin
		chk(m2, 8'h11, 8'h0, 16'h0223, 3'b010, 3'b010);
		chk(m3, 8'h11, 8'h0, 16'h0223, 3'b000, 3'b010);
		chk(m1, 8'h11, 8'h0, 16'h0223, 3'b010, 3'b000);
		chk(m3, 8'h3a, 8'h0, 16'h0223, 3'b010, 3'b000);
		chk(m2, 8'h11, 8'h0, 16'h0222, 3'b011, 3'b100);
		chk(m3, 8'h11, 8'h0, 16'h0222, 3'b100, 3'b000);
		$display("dhcp end");
	end
	endtask
	task t_misc;
	begin
		et = 16'h0800;
		chk(m1, 8'h3a, 8'h86, 16'h0, 3'b001, 3'b000);
		et = 16'h86dd;
		am = 1'b1;
		chk(m1, 8'h3a, 8'h86, 16'h0, 3'b000, 3'b001);
		am = 1'b0;
		gf = 1'b0;
		chk(m1, 8'h3a, 8'h86, 16'h0, 3'b000, 3'b001);
		gf = 1'b1;
		chk(m2, 8'h11, 8'h0, 16'h0223, 3'b111, 3'b010);
		checks_done = checks_done + 1;
		if (sup !== 3'b111)
		begin
			bad_count = bad_count + 1;
			$display("BAD %0t supported %b", $time, sup);
		end
		$display("misc end");
	end
	endtask
	initial
	begin
		repeat (12) @(negedge clk);
		arst_n = 1'b1;
		gf = 1'b1;
		t_ra;
		t_dhcp;
		t_misc;
		end_of_test;
	end
	initial
	begin
		#500000;
		bad_count = bad_count + 1;
		end_of_test;
	end
endmodule // ipv6_multicast_class_filter_bench
